//--- hw/flo_pkg.sv
package flo_pkg;

  // ---------------------------------------------------------------
  // Sample and weight formats
  // ---------------------------------------------------------------
  localparam int SMP_W = 16;
  localparam int WGT_W = 17;
  localparam int PROD_W = SMP_W + WGT_W + 1;
  localparam int MUL_SHIFT = 15;
  localparam logic signed [SMP_W-1:0] SMP_MAX = 16'h7FFF;
  localparam logic signed [SMP_W-1:0] SMP_MIN = 16'h8000;
  localparam logic [WGT_W-1:0] WGT_ONE = 17'h08000;
  // 0.70795 in Q15, a 3 dB cut
  localparam logic [WGT_W-1:0] SCALE_3DB = 17'h05A9E;

  // ---------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------
  localparam int FRAME_LEN = 32;
  localparam int OVERLAP_LEN = 8;
  localparam int BLK_LEN = FRAME_LEN + OVERLAP_LEN;
  localparam int IDX_W = 6;
  localparam int OVL_IDX_W = 3;
  localparam logic [IDX_W-1:0] K_ZERO = 6'h00;
  localparam logic [IDX_W-1:0] K_ONE = 6'h01;
  localparam logic [IDX_W-1:0] K_OVL = 6'h08;
  localparam logic [IDX_W-1:0] K_OVL_LAST = 6'h07;
  localparam logic [IDX_W-1:0] K_EVAL_LAST = 6'h0F;
  localparam logic [IDX_W-1:0] K_FRAME = 6'h20;
  localparam logic [IDX_W-1:0] K_FRAME_LAST = 6'h1F;
  localparam logic [IDX_W-1:0] K_BLK_LAST = 6'h27;

  // Squared sine weights sin^2(pi*k/(2*OVERLAP_LEN)), Q15
  localparam logic [WGT_W-1:0] WIN_TAB [OVERLAP_LEN] = '{
    17'h00000, 17'h004DF, 17'h012BF, 17'h02782,
    17'h04000, 17'h0587E, 17'h06D41, 17'h07B21
  };

  // ---------------------------------------------------------------
  // Energy check
  // ---------------------------------------------------------------
  localparam int ENERGY_W = 32;
  localparam int ENERGY_SHIFT = 2;
  localparam logic [ENERGY_W-1:0] ENERGY_ZERO = 32'h0000_0000;
  localparam logic [ENERGY_W-1:0] ENERGY_THR_DEF = 32'h0100_0000;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADR_W-1:0] THR_OFS = 8'h04;
  localparam logic [ADR_W-1:0] STAT_OFS = 8'h08;
  localparam int CTRL_PLAIN_BIT = 0;
  localparam int STAT_FALLBACK_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam logic [31:0] WB_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_CONV,
    MODE_ERASED,
    MODE_NEXT_GOOD,
    MODE_BURST
  } flo_mode_e;

endpackage

//--- hw/flo_win.sv
`timescale 1ns/1ps
module flo_win
  import flo_pkg::*;
(
  input wire logic [OVL_IDX_W-1:0] idx_i,
  output logic [WGT_W-1:0] w_o,
  output logic [WGT_W-1:0] wc_o
);

  // ---------------------------------------------------------------
  // Rising half and its exact complement
  // ---------------------------------------------------------------
  assign w_o = WIN_TAB[idx_i];
  // Complement by subtraction so both halves sum to one exactly
  assign wc_o = WGT_ONE - WIN_TAB[idx_i];

endmodule

//--- hw/flo_skid.sv
`timescale 1ns/1ps
module flo_skid
  import flo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic signed [SMP_W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic signed [SMP_W-1:0] out_data_o
);

  logic head_v_reg;
  logic spare_v_reg;
  logic signed [SMP_W-1:0] head_reg;
  logic signed [SMP_W-1:0] spare_reg;
  logic pop;
  logic push;

  assign in_ready_o = ~spare_v_reg;
  assign out_valid_o = head_v_reg;
  assign out_data_o = head_reg;
  assign pop = head_v_reg & out_ready_i;
  assign push = in_valid_i & ~spare_v_reg;

  // ---------------------------------------------------------------
  // Two entries; outputs straight from the head register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_v_reg <= 1'b0;
      spare_v_reg <= 1'b0;
      head_reg <= SMP_MIN;
      spare_reg <= SMP_MIN;
    end else if (pop) begin
      if (spare_v_reg) begin
        head_reg <= spare_reg;
        spare_v_reg <= 1'b0;
      end else if (push) begin
        head_reg <= in_data_i;
      end else begin
        head_v_reg <= 1'b0;
      end
    end else if (push) begin
      if (!head_v_reg) begin
        head_reg <= in_data_i;
        head_v_reg <= 1'b1;
      end else begin
        spare_reg <= in_data_i;
        spare_v_reg <= 1'b1;
      end
    end
  end

endmodule

//--- hw/flo_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Conventional mode windows the current block and adds it to the stored previous tail.
// - An erased frame reuses the tail kept from two frames back at its start.
// - An erased frame overlap-adds that repeated tail with its own windowed block.
// - An erased frame cross-fades from the previous output tail into the repeated result.
// - Each smoothing window pair sums exactly to one over the overlap.
// - The smoothing weight for index k is the squared sine of pi*k/(2*overlap_len).
// - After erasure concealment, a dropped or far-off overlap energy falls back to conventional.
// - The first good frame after a single erasure is only cross-faded from the old tail.
// - The post-burst path is taken only for a stationary input after a burst of erasures.
// - The post-burst path copies the next-frame tail of the block to the frame start.
// - The post-burst path attenuates the current frame by 3 dB.
// - The post-burst path cross-fades the old tail into the copy and uses that as the old tail.
// - The post-burst path then cross-fades that substitute into the current samples.
// - The plain variant replaces the second cross-fade with a plain overlap-add.
module flo_top
  import flo_pkg::*;
#(
  parameter logic [ENERGY_W-1:0] ENERGY_THR = ENERGY_THR_DEF
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic signed [SMP_W-1:0] in_data_i,
  input wire logic erased_i,
  input wire logic prev_burst_i,
  input wire logic stationary_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic signed [SMP_W-1:0] out_data_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  typedef enum logic [2:0] {
    ST_LOAD,
    ST_EVAL,
    ST_DECIDE,
    ST_EMIT,
    ST_UPD
  } flo_state_e;

  // ---------------------------------------------------------------
  // Arithmetic helpers
  // ---------------------------------------------------------------
  function automatic logic signed [SMP_W-1:0] mulw(input logic signed [SMP_W-1:0] a,
                                                   input logic [WGT_W-1:0] w);
    logic signed [PROD_W-1:0] p;
    p = a * $signed({1'b0, w});
    mulw = p[MUL_SHIFT +: SMP_W];
  endfunction

  function automatic logic signed [SMP_W-1:0] sadd(input logic signed [SMP_W-1:0] a,
                                                   input logic signed [SMP_W-1:0] b);
    logic signed [SMP_W:0] s;
    s = {a[SMP_W-1], a} + {b[SMP_W-1], b};
    if (s[SMP_W] != s[SMP_W-1]) begin
      sadd = s[SMP_W] ? SMP_MIN : SMP_MAX;
    end else begin
      sadd = s[SMP_W-1:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  flo_state_e state_reg;
  flo_mode_e mode_reg;
  flo_mode_e calc_mode;
  flo_mode_e last_mode_reg;
  logic [IDX_W-1:0] k_reg;
  logic signed [SMP_W-1:0] cur_mem [BLK_LEN];
  logic signed [SMP_W-1:0] old_tail [OVERLAP_LEN];
  logic signed [SMP_W-1:0] prev_old [OVERLAP_LEN];
  logic in_ready_reg;
  logic erased_reg;
  logic burst_reg;
  logic stat_reg;
  logic prev_erased_reg;
  logic fallback_reg;
  logic last_fallback_reg;
  logic plain_reg;
  logic [ENERGY_W-1:0] thr_reg;
  logic [ENERGY_W-1:0] overlap_energy;
  logic [ENERGY_W-1:0] nonoverlap_energy;
  logic [ENERGY_W-1:0] energy_diff;
  logic ack_reg;
  logic [31:0] rd_reg;
  logic take;
  logic [OVL_IDX_W-1:0] kl;
  logic [WGT_W-1:0] w;
  logic [WGT_W-1:0] wc;
  logic buf_valid;
  logic buf_ready;
  logic signed [SMP_W-1:0] smp;
  logic signed [SMP_W-1:0] tail_val;
  logic signed [2*SMP_W-1:0] sq;
  logic [ENERGY_W-1:0] e_add;
  logic wb_req;

  assign take = in_valid_i & in_ready_reg;
  assign kl = k_reg[OVL_IDX_W-1:0];
  assign buf_valid = (state_reg == ST_EMIT);
  assign in_ready_o = in_ready_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;

  flo_win u_win (
    .idx_i(kl),
    .w_o(w),
    .wc_o(wc)
  );

  // ---------------------------------------------------------------
  // Per-sample datapath
  // ---------------------------------------------------------------
  always_comb begin
    logic signed [SMP_W-1:0] x;
    logic signed [SMP_W-1:0] xs;
    logic signed [SMP_W-1:0] cs;
    logic signed [SMP_W-1:0] ot;
    logic signed [SMP_W-1:0] rep;
    logic signed [SMP_W-1:0] s1;
    x = cur_mem[k_reg];
    ot = old_tail[kl];
    xs = mulw(x, SCALE_3DB);
    cs = mulw(cur_mem[FRAME_LEN + 32'(kl)], SCALE_3DB);
    rep = sadd(prev_old[kl], mulw(x, w));
    s1 = sadd(mulw(ot, wc), mulw(cs, w));
    calc_mode = (state_reg == ST_EVAL) ? MODE_ERASED : mode_reg;
    smp = x;
    if (k_reg < K_OVL) begin
      case (calc_mode)
        MODE_CONV: smp = sadd(ot, mulw(x, w));
        MODE_ERASED: smp = sadd(mulw(ot, wc), mulw(rep, w));
        MODE_NEXT_GOOD: smp = sadd(mulw(ot, wc), mulw(x, w));
        default: begin
          if (plain_reg) begin
            smp = sadd(s1, mulw(xs, w));
          end else begin
            smp = sadd(mulw(s1, wc), mulw(xs, w));
          end
        end
      endcase
    end else if (calc_mode == MODE_BURST) begin
      smp = xs;
    end
    // Next frame's tail, windowed by the falling half
    tail_val = mulw((mode_reg == MODE_BURST) ? cs : cur_mem[FRAME_LEN + 32'(kl)], wc);
    sq = smp * smp;
    e_add = $unsigned(sq) >> ENERGY_SHIFT;
  end

  assign energy_diff = (overlap_energy > nonoverlap_energy) ?
                       (overlap_energy - nonoverlap_energy) :
                       (nonoverlap_energy - overlap_energy);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_LOAD;
      k_reg <= K_ZERO;
    end else begin
      case (state_reg)
        ST_LOAD: begin
          if (take) begin
            if (k_reg == K_BLK_LAST) begin
              k_reg <= K_ZERO;
              state_reg <= erased_reg ? ST_EVAL : ST_EMIT;
            end else begin
              k_reg <= k_reg + K_ONE;
            end
          end
        end
        ST_EVAL: begin
          if (k_reg == K_EVAL_LAST) begin
            k_reg <= K_ZERO;
            state_reg <= ST_DECIDE;
          end else begin
            k_reg <= k_reg + K_ONE;
          end
        end
        ST_DECIDE: state_reg <= ST_EMIT;
        ST_EMIT: begin
          if (buf_ready) begin
            if (k_reg == K_FRAME_LAST) begin
              k_reg <= K_ZERO;
              state_reg <= ST_UPD;
            end else begin
              k_reg <= k_reg + K_ONE;
            end
          end
        end
        default: begin
          if (k_reg == K_OVL_LAST) begin
            k_reg <= K_ZERO;
            state_reg <= ST_LOAD;
          end else begin
            k_reg <= k_reg + K_ONE;
          end
        end
      endcase
    end
  end

  // Ready drops on the last word so no extra word slips in
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_ready_reg <= 1'b1;
    end else if (take && k_reg == K_BLK_LAST) begin
      in_ready_reg <= 1'b0;
    end else if (state_reg == ST_UPD && k_reg == K_OVL_LAST) begin
      in_ready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (take) begin
      cur_mem[k_reg] <= in_data_i;
    end
  end

  // ---------------------------------------------------------------
  // Frame flags and path choice
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erased_reg <= 1'b0;
      burst_reg <= 1'b0;
      stat_reg <= 1'b0;
    end else if (take && k_reg == K_ZERO) begin
      erased_reg <= erased_i;
      burst_reg <= prev_burst_i;
      stat_reg <= stationary_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= MODE_CONV;
      fallback_reg <= 1'b0;
    end else if (take && k_reg == K_BLK_LAST) begin
      fallback_reg <= 1'b0;
      if (erased_reg) begin
        mode_reg <= MODE_ERASED;
      end else if (burst_reg && stat_reg) begin
        mode_reg <= MODE_BURST;
      end else if (prev_erased_reg && !burst_reg) begin
        mode_reg <= MODE_NEXT_GOOD;
      end else begin
        mode_reg <= MODE_CONV;
      end
    end else if (state_reg == ST_DECIDE) begin
      // Energy dip or a large gap means the concealment would sound worse
      if (overlap_energy < nonoverlap_energy || energy_diff > thr_reg) begin
        mode_reg <= MODE_CONV;
        fallback_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overlap_energy <= ENERGY_ZERO;
      nonoverlap_energy <= ENERGY_ZERO;
    end else if (take && k_reg == K_BLK_LAST) begin
      overlap_energy <= ENERGY_ZERO;
      nonoverlap_energy <= ENERGY_ZERO;
    end else if (state_reg == ST_EVAL) begin
      if (k_reg < K_OVL) begin
        overlap_energy <= overlap_energy + e_add;
      end else begin
        nonoverlap_energy <= nonoverlap_energy + e_add;
      end
    end
  end

  // ---------------------------------------------------------------
  // Tail history
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < OVERLAP_LEN; i++) begin
        old_tail[i] <= '0;
        prev_old[i] <= '0;
      end
    end else if (state_reg == ST_UPD) begin
      prev_old[kl] <= old_tail[kl];
      old_tail[kl] <= tail_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_erased_reg <= 1'b0;
      last_mode_reg <= MODE_CONV;
      last_fallback_reg <= 1'b0;
    end else if (state_reg == ST_UPD && k_reg == K_OVL_LAST) begin
      prev_erased_reg <= erased_reg;
      last_mode_reg <= mode_reg;
      last_fallback_reg <= fallback_reg;
    end
  end

  flo_skid u_skid (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(buf_valid),
    .in_ready_o(buf_ready),
    .in_data_i(smp),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o)
  );

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rd_reg <= WB_ZERO;
    end else begin
      ack_reg <= wb_req;
      if (wb_req) begin
        if (wb_adr_i == CTRL_OFS) begin
          rd_reg <= {31'h0000_0000, plain_reg};
        end else if (wb_adr_i == THR_OFS) begin
          rd_reg <= thr_reg;
        end else if (wb_adr_i == STAT_OFS) begin
          rd_reg <= {28'h000_0000, state_reg != ST_LOAD, last_fallback_reg, last_mode_reg};
        end else begin
          rd_reg <= WB_ZERO;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      plain_reg <= 1'b0;
      thr_reg <= ENERGY_THR;
    end else if (wb_req && wb_we_i) begin
      if (wb_adr_i == CTRL_OFS) begin
        if (wb_sel_i[0]) begin
          plain_reg <= wb_dat_i[CTRL_PLAIN_BIT];
        end
      end else if (wb_adr_i == THR_OFS) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            thr_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
    end
  end

endmodule

//--- bench/flo_top_sva.sv
`timescale 1ns/1ps
module flo_top_sva
  import flo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic in_ready_o,
  input wire logic signed [SMP_W-1:0] in_data_i,
  input wire logic erased_i,
  input wire logic prev_burst_i,
  input wire logic stationary_i,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic signed [SMP_W-1:0] out_data_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  // ----
  // Frame tracking
  // ----
  logic [IDX_W-1:0] take_cnt_reg;
  logic er_reg;
  logic [7:0] low_cnt_reg;
  wire logic take = in_valid_i && in_ready_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) take_cnt_reg <= K_ZERO;
    else if (take) take_cnt_reg <= (take_cnt_reg == K_BLK_LAST) ? K_ZERO : take_cnt_reg + K_ONE;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) er_reg <= 1'b0;
    else if (take && take_cnt_reg == K_ZERO) er_reg <= erased_i;
  end
  // Saturates so a long output stall cannot wrap it
  always_ff @(posedge clk_i) begin
    if (rst_i || in_ready_o) low_cnt_reg <= 8'h00;
    else if (low_cnt_reg != 8'hFF) low_cnt_reg <= low_cnt_reg + 8'h01;
  end
  // ----
  // Assertions
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  blk_end_a: assert property (take && take_cnt_reg == K_BLK_LAST |=> !in_ready_o)
    else $error("input not stalled after block end");
  conv_busy_a: assert property ($rose(in_ready_o) && !er_reg |-> low_cnt_reg >= 8'd40)
    else $error("good frame finished too early");
  eval_busy_a: assert property ($rose(in_ready_o) && er_reg |-> low_cnt_reg >= 8'd57)
    else $error("erased frame skipped energy pass");
  out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("output sample lost under stall");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acked in one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
    wb_adr_i > 8'h0B |=> wb_dat_o == WB_ZERO) else $error("unmapped read not zero");
endmodule

bind flo_top flo_top_sva flo_top_sva_inst (
  .clk_i(clk_i), .rst_i(rst_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
  .in_data_i(in_data_i), .erased_i(erased_i), .prev_burst_i(prev_burst_i),
  .stationary_i(stationary_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .out_data_o(out_data_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o)
);

//--- bench/flo_src.sv
`timescale 1ns/1ps
module flo_src
  import flo_pkg::*;
(
  input wire logic clk_i,
  input wire logic in_ready_i,
  output logic in_valid_o,
  output logic signed [SMP_W-1:0] in_data_o,
  output logic erased_o,
  output logic prev_burst_o,
  output logic stationary_o
);
  // ----
  // Upstream block source
  // ----
  initial begin
    in_valid_o = 1'b0;
    in_data_o = 16'h0000;
    erased_o = 1'b0;
    prev_burst_o = 1'b0;
    stationary_o = 1'b0;
  end
  function automatic int blk_val(input int a, input int b, input int k);
    return (k < FRAME_LEN) ? a + 64 * k : b;
  endfunction
  // Gap makes a slow source; idle data is inverted so stale reads show
  task automatic send_block(input int a, input int b, input logic er, input logic pb,
                            input logic st, input int gap);
    for (int k = 0; k < BLK_LEN; k++) begin
      if (gap > 0) begin
        in_valid_o <= 1'b0;
        in_data_o <= ~in_data_o;
        repeat (gap) @(posedge clk_i);
      end
      in_valid_o <= 1'b1;
      in_data_o <= SMP_W'(blk_val(a, b, k));
      erased_o <= (k == 0) ? er : ~er;
      prev_burst_o <= (k == 0) ? pb : ~pb;
      stationary_o <= (k == 0) ? st : ~st;
      do @(posedge clk_i); while (!in_ready_i);
    end
    in_valid_o <= 1'b0;
    in_data_o <= ~in_data_o;
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb
  import flo_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic in_valid_i, in_ready_o, erased_i, prev_burst_i, stationary_i, out_valid_o, wb_ack_o;
  logic signed [SMP_W-1:0] in_data_i, out_data_o;
  logic out_ready_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, stall_en = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic [31:0] thr = ENERGY_THR_DEF;
  logic [1:0] cyc_reg = 2'h0;
  logic signed [SMP_W-1:0] got[$], ex[FRAME_LEN];
  logic signed [SMP_W-1:0] tl[OVERLAP_LEN] = '{default: '0}, po[OVERLAP_LEN] = '{default: '0};
  logic prev_er = 1'b0, plain = 1'b0;
  int error_cnt = 0, n_tests = 0;

  flo_top flo_top_inst (.clk_i(clk_i), .rst_i(rst_i), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .in_data_i(in_data_i), .erased_i(erased_i),
    .prev_burst_i(prev_burst_i), .stationary_i(stationary_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_data_o(out_data_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  flo_src flo_src_inst (.clk_i(clk_i), .in_ready_i(in_ready_o), .in_valid_o(in_valid_i),
    .in_data_o(in_data_i), .erased_o(erased_i), .prev_burst_o(prev_burst_i),
    .stationary_o(stationary_i));

  always #12.5 clk_i = ~clk_i;
  // Sink stalls three cycles in four when asked
  always @(posedge clk_i) begin
    cyc_reg <= cyc_reg + 2'h1;
    out_ready_i <= !(stall_en && cyc_reg != 2'h0);
    if (!rst_i && out_valid_o && out_ready_i) got.push_back(out_data_o);
  end
  // ----
  // Reference arithmetic
  // ----
  function automatic longint mw(input longint a, input longint w);
    return (a * w) >>> MUL_SHIFT;
  endfunction
  function automatic logic signed [SMP_W-1:0] sat(input longint v);
    return (v > 32767) ? SMP_MAX : (v < -32768) ? SMP_MIN : SMP_W'(v);
  endfunction
  task automatic model(input int a, input int b, input logic er, input logic pb,
                       input logic st, output logic [1:0] md, output logic fb);
    longint x, w, wc, c, s1, xs, y, ov, nov;
    logic signed [SMP_W-1:0] cv[OVERLAP_LEN], nt[OVERLAP_LEN];
    md = er ? 2'h1 : (pb && st) ? 2'h3 : (prev_er && !pb) ? 2'h2 : 2'h0;
    fb = 1'b0;
    ov = 0;
    nov = 0;
    for (int k = 0; k < FRAME_LEN; k++) begin
      x = flo_src_inst.blk_val(a, b, k);
      xs = mw(x, SCALE_3DB);
      ex[k] = (md == 2'h3) ? xs : x;
      if (k < OVERLAP_LEN) begin
        w = WIN_TAB[k];
        wc = WGT_ONE - w;
        c = mw(flo_src_inst.blk_val(a, b, FRAME_LEN + k), SCALE_3DB);
        s1 = sat(mw(tl[k], wc) + mw(c, w));
        nt[k] = mw((md == 2'h3) ? c : flo_src_inst.blk_val(a, b, FRAME_LEN + k), wc);
        cv[k] = sat(tl[k] + mw(x, w));
        case (md)
          2'h0: ex[k] = cv[k];
          2'h1: ex[k] = sat(mw(tl[k], wc) + mw(sat(po[k] + mw(x, w)), w));
          2'h2: ex[k] = sat(mw(tl[k], wc) + mw(x, w));
          default: ex[k] = plain ? sat(s1 + mw(xs, w)) : sat(mw(s1, wc) + mw(xs, w));
        endcase
        y = ex[k];
        ov += (y * y) >>> ENERGY_SHIFT;
      end else if (k < 2 * OVERLAP_LEN) begin
        y = ex[k];
        nov += (y * y) >>> ENERGY_SHIFT;
      end
    end
    if (md == 2'h1 && (ov < nov || ((ov > nov) ? ov - nov : nov - ov) > thr)) begin
      md = 2'h0;
      fb = 1'b1;
      for (int k = 0; k < OVERLAP_LEN; k++) ex[k] = cv[k];
    end
    po = tl;
    tl = nt;
    prev_er = er;
  endtask
  // ----
  // Bus and frame helpers
  // ----
  task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] d,
                    input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    `CHK("wb_ack", 1'b1, wb_ack_o)
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic do_frame(input int a, input int b, input logic er, input logic pb,
                          input logic st, input int gap);
    logic [1:0] md;
    logic fb;
    logic [31:0] rd;
    int n;
    model(a, b, er, pb, st, md, fb);
    got.delete();
    @(posedge clk_i);
    flo_src_inst.send_block(a, b, er, pb, st, gap);
    for (n = 0; n < 400 && got.size() < FRAME_LEN; n++) @(posedge clk_i);
    for (n = 0; n < 400 && in_ready_o !== 1'b1; n++) @(posedge clk_i);
    for (n = 0; n < FRAME_LEN; n++) `CHK("sample", ex[n], got[n])
    wb(1'b0, STAT_OFS, WB_ZERO, 4'hF, rd);
    `CHK("mode", md, rd[1:0])
    `CHK("fallback", fb, rd[STAT_FALLBACK_BIT])
    `CHK("count", FRAME_LEN, got.size())
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    logic [31:0] rd;
    wb(1'b0, THR_OFS, WB_ZERO, 4'hF, rd);
    `CHK("thr_rst", ENERGY_THR_DEF, rd)
    wb(1'b1, THR_OFS, 32'hFFFF_FFFF, 4'hF, rd);
    wb(1'b1, THR_OFS, 32'h0000_0012, 4'h1, rd);
    wb(1'b0, THR_OFS, WB_ZERO, 4'hF, rd);
    thr = 32'hFFFF_FF12;
    `CHK("thr_sel", thr, rd)
    wb(1'b0, 8'h0C, WB_ZERO, 4'hF, rd);
    `CHK("unmapped", WB_ZERO, rd)
  endtask
  task automatic t_conv();
    for (int k = 0; k < OVERLAP_LEN; k++) `CHK("weight", WGT_W'($rtoi(32768.0 * $sin(3.14159265358979 * k / (2.0 * OVERLAP_LEN)) ** 2 + 0.5)), WIN_TAB[k])
    do_frame(1000, 20000, 1'b0, 1'b0, 1'b0, 0);
  endtask
  task automatic t_erased();
    do_frame(500, 20000, 1'b1, 1'b0, 1'b0, 0);
  endtask
  task automatic t_next_good();
    stall_en <= 1'b1;
    do_frame(-3000, -20000, 1'b0, 1'b0, 1'b0, 2);
    stall_en <= 1'b0;
  endtask
  task automatic t_fallback();
    do_frame(100, 0, 1'b0, 1'b0, 1'b0, 0);
    do_frame(8000, 5000, 1'b1, 1'b0, 1'b0, 0);
  endtask
  task automatic t_burst();
    do_frame(200, 10000, 1'b1, 1'b0, 1'b0, 0);
    do_frame(4000, 12000, 1'b0, 1'b1, 1'b1, 0);
  endtask
  task automatic t_burst_plain();
    logic [31:0] rd;
    wb(1'b1, CTRL_OFS, 32'h0000_0001, 4'h1, rd);
    wb(1'b0, CTRL_OFS, WB_ZERO, 4'hF, rd);
    `CHK("ctrl", 1'b1, rd[CTRL_PLAIN_BIT])
    plain = 1'b1;
    do_frame(4000, 12000, 1'b0, 1'b1, 1'b1, 1);
  endtask
  task automatic t_burst_nonstat();
    do_frame(300, -9000, 1'b1, 1'b0, 1'b0, 0);
    do_frame(-2000, 3000, 1'b0, 1'b1, 1'b0, 0);
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_conv();
    t_erased();
    t_next_good();
    t_fallback();
    t_burst();
    t_burst_plain();
    t_burst_nonstat();
    finish_test();
  end
  // Ten frames need about twelve hundred cycles; this is far past that
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end
endmodule
